// ### hdl/backoff_sel.v
`default_nettype none

// Per-port back-off and excessive collision selection.
module backoff_sel (
    input wire clk,
    input wire rst,
    input wire alt_en,
    input wire aggr_en,
    input wire keep_exc_coll,
    input wire [6:0] half_duplex,
    input wire [6:0] exc_coll,
    output reg [6:0] alt_backoff,
    output reg [6:0] aggr_backoff,
    output reg [6:0] exc_coll_drop
);

    genvar i;

    generate
        for (i = 0; i < 7; i = i + 1) begin : g_port
            always @(posedge clk) begin
                if (rst) begin
                    alt_backoff[i] <= 1'b0;
                    aggr_backoff[i] <= 1'b0;
                    exc_coll_drop[i] <= 1'b0;
                end else begin
                    // Full-duplex ports never use the alternate algorithm.
                    alt_backoff[i] <= alt_en & half_duplex[i];
                    aggr_backoff[i] <= aggr_en & half_duplex[i];
                    exc_coll_drop[i] <= exc_coll[i] & ~keep_exc_coll;
                end
            end
        end
    endgenerate

endmodule // backoff_sel

`default_nettype wire

// ### hdl/frame_filter.v
`default_nettype none

// Decides whether a received frame is discarded by the MAC checks.
module frame_filter (
    input wire len_check_en,
    input wire fc_drop_mode,
    input wire [15:0] ethertype,
    input wire [47:0] dest_addr,
    input wire [15:0] actual_len,
    output wire drop,
    output wire len_drop,
    output wire fc_drop
);

`include "switch_ctrl_map.vh"

    wire type_hit;
    wire da_hit;

    assign type_hit = (ethertype == `FC_ETHERTYPE);
    assign da_hit = (dest_addr == `FC_DEST_ADDR);

    // Length field is only checked below the limit.
    assign len_drop = len_check_en && (ethertype < `LEN_FIELD_LIMIT)
                      && (actual_len != ethertype);

    // Either match drops in mode one, both needed in mode zero.
    assign fc_drop = fc_drop_mode ? (type_hit | da_hit)
                                  : (type_hit & da_hit);

    assign drop = len_drop | fc_drop;

endmodule // frame_filter

`default_nettype wire

// ### hdl/switch_ctrl_map.vh
`ifndef SWITCH_CTRL_MAP_VH
`define SWITCH_CTRL_MAP_VH

// Register offsets on the management port.
`define UVF_CTRL_OFFSET 12'h328
`define MAC_CTRL_ZERO_OFFSET 12'h330
`define COLL_POLICY_OFFSET 12'h334

// Field positions of the unknown-VLAN forwarding register.
`define UVF_EN_BIT 31
`define UVF_MASK_MSB 6
`define UVF_MASK_LSB 0

// Field positions of the MAC control register.
`define MAC_ALT_BACKOFF_BIT 7
`define MAC_RSV_HI_MSB 6
`define MAC_RSV_HI_LSB 4
`define MAC_LEN_CHECK_BIT 3
`define MAC_RSV_LO_BIT 2
`define MAC_FC_DROP_MODE_BIT 1
`define MAC_AGGR_BACKOFF_BIT 0

// Field position of the collision policy register.
`define COLL_KEEP_BIT 0

// Reset values.
`define UVF_CTRL_RESET 32'h0000_0000
`define MAC_CTRL_ZERO_RESET 8'h04
`define COLL_POLICY_RESET 1'h0

// Frame matching constants.
`define LEN_FIELD_LIMIT 16'h05dc
`define FC_ETHERTYPE 16'h8808
`define FC_DEST_ADDR 48'h0180_c200_0001

// Forwarding class codes.
`define CLASS_NONE 2'h0
`define CLASS_UVID 2'h1
`define CLASS_UUCAST 2'h2
`define CLASS_UMCAST 2'h3

`endif

// ### hdl/unknown_vid_and_mac_ctrl.v
// Contract
// - Enable bit sends unknown-VLAN frames to mask.
// - Seven-bit mask, bit 0 is port 1.
// - Set bits forward, clear bits omit ports.
// - Precedence: unknown VLAN, unicast, then multicast.
// - Alternate back-off, half-duplex ports only.
// - Keep frames after 16 collisions when enabled.
// - Length check drops mismatched short length fields.
// - Drop mode one drops either flow match.
// - Drop mode zero drops only both matching.
// - Bit 0 enables aggressive half-duplex back-off.
`default_nettype none

module unknown_vid_and_mac_ctrl (
    input wire clk,
    input wire rst,
    input wire [11:0] addr,
    input wire [31:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [31:0] rdata,
    input wire rx_valid,
    input wire rx_unknown_vid,
    input wire rx_unknown_ucast,
    input wire rx_unknown_mcast,
    input wire [15:0] rx_ethertype,
    input wire [47:0] rx_dest_addr,
    input wire [15:0] rx_actual_len,
    input wire ucast_fwd_en,
    input wire [6:0] ucast_fwd_mask,
    input wire mcast_fwd_en,
    input wire [6:0] mcast_fwd_mask,
    output reg dec_valid,
    output reg dec_drop,
    output reg dec_len_drop,
    output reg dec_fc_drop,
    output reg dec_fwd_hit,
    output reg [6:0] dec_fwd_mask,
    output reg [1:0] dec_class,
    input wire [6:0] half_duplex,
    input wire [6:0] exc_coll,
    output wire [6:0] alt_backoff,
    output wire [6:0] aggr_backoff,
    output wire [6:0] exc_coll_drop,
    output wire len_check_en,
    output wire fc_drop_mode
);

`include "switch_ctrl_map.vh"

    reg uvf_en_r;
    reg [6:0] uvf_mask_r;
    reg uvf_en_nxt;
    reg [6:0] uvf_mask_nxt;
    reg mac_alt_r;
    reg mac_alt_nxt;
    reg [2:0] mac_rsv_hi_r;
    reg [2:0] mac_rsv_hi_nxt;
    reg mac_len_chk_r;
    reg mac_len_chk_nxt;
    reg mac_rsv_lo_r;
    reg mac_rsv_lo_nxt;
    reg mac_fc_mode_r;
    reg mac_fc_mode_nxt;
    reg mac_aggr_r;
    reg mac_aggr_nxt;
    reg coll_keep_r;
    reg coll_keep_nxt;

    reg [31:0] rdata_nxt;
    reg [1:0] class_nxt;
    reg hit_nxt;
    reg [6:0] cat_mask;
    reg dec_drop_nxt;
    reg dec_len_drop_nxt;
    reg dec_fc_drop_nxt;
    reg dec_fwd_hit_nxt;
    reg [6:0] dec_fwd_mask_nxt;
    reg [1:0] dec_class_nxt;

    wire sel_uvf;
    wire sel_mac;
    wire sel_coll;
    wire filt_drop;
    wire filt_len_drop;
    wire filt_fc_drop;
    wire alt_en;
    wire aggr_en;
    wire [6:0] mask_nxt;
    wire [7:0] mac_ctrl_word;
    wire wr_uvf;
    wire wr_mac;
    wire wr_coll;

    localparam [31:0] UVF_RESET_WORD = `UVF_CTRL_RESET;
    localparam [7:0] MAC_RESET_BYTE = `MAC_CTRL_ZERO_RESET;

    assign sel_uvf = (addr == `UVF_CTRL_OFFSET);
    assign sel_mac = (addr == `MAC_CTRL_ZERO_OFFSET);
    assign sel_coll = (addr == `COLL_POLICY_OFFSET);

    assign wr_uvf = wr_en && sel_uvf;
    assign wr_mac = wr_en && sel_mac;
    assign wr_coll = wr_en && sel_coll;

    assign alt_en = mac_alt_r;
    assign aggr_en = mac_aggr_r;
    assign len_check_en = mac_len_chk_r;
    assign fc_drop_mode = mac_fc_mode_r;

    // Reassembles the MAC control byte for read-back.
    assign mac_ctrl_word[`MAC_ALT_BACKOFF_BIT] = mac_alt_r;
    assign mac_ctrl_word[`MAC_RSV_HI_MSB:`MAC_RSV_HI_LSB] = mac_rsv_hi_r;
    assign mac_ctrl_word[`MAC_LEN_CHECK_BIT] = mac_len_chk_r;
    assign mac_ctrl_word[`MAC_RSV_LO_BIT] = mac_rsv_lo_r;
    assign mac_ctrl_word[`MAC_FC_DROP_MODE_BIT] = mac_fc_mode_r;
    assign mac_ctrl_word[`MAC_AGGR_BACKOFF_BIT] = mac_aggr_r;

    // Unknown-VLAN forwarding register; the reserved middle bits are not stored.
    always @* begin
        uvf_en_nxt = uvf_en_r;
        uvf_mask_nxt = uvf_mask_r;
        if (wr_uvf) begin
            uvf_en_nxt = wdata[`UVF_EN_BIT];
            uvf_mask_nxt = wdata[`UVF_MASK_MSB:`UVF_MASK_LSB];
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            uvf_en_r <= UVF_RESET_WORD[`UVF_EN_BIT];
            uvf_mask_r <= UVF_RESET_WORD[`UVF_MASK_MSB:`UVF_MASK_LSB];
        end else begin
            uvf_en_r <= uvf_en_nxt;
            uvf_mask_r <= uvf_mask_nxt;
        end
    end

    // MAC control register; reserved bits are stored as written.
    always @* begin
        mac_alt_nxt = mac_alt_r;
        mac_rsv_hi_nxt = mac_rsv_hi_r;
        mac_len_chk_nxt = mac_len_chk_r;
        mac_rsv_lo_nxt = mac_rsv_lo_r;
        mac_fc_mode_nxt = mac_fc_mode_r;
        mac_aggr_nxt = mac_aggr_r;
        if (wr_mac) begin
            mac_alt_nxt = wdata[`MAC_ALT_BACKOFF_BIT];
            mac_rsv_hi_nxt = wdata[`MAC_RSV_HI_MSB:`MAC_RSV_HI_LSB];
            mac_len_chk_nxt = wdata[`MAC_LEN_CHECK_BIT];
            mac_rsv_lo_nxt = wdata[`MAC_RSV_LO_BIT];
            mac_fc_mode_nxt = wdata[`MAC_FC_DROP_MODE_BIT];
            mac_aggr_nxt = wdata[`MAC_AGGR_BACKOFF_BIT];
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            mac_alt_r <= MAC_RESET_BYTE[`MAC_ALT_BACKOFF_BIT];
            mac_rsv_hi_r <= MAC_RESET_BYTE[`MAC_RSV_HI_MSB:`MAC_RSV_HI_LSB];
            mac_len_chk_r <= MAC_RESET_BYTE[`MAC_LEN_CHECK_BIT];
            mac_rsv_lo_r <= MAC_RESET_BYTE[`MAC_RSV_LO_BIT];
            mac_fc_mode_r <= MAC_RESET_BYTE[`MAC_FC_DROP_MODE_BIT];
            mac_aggr_r <= MAC_RESET_BYTE[`MAC_AGGR_BACKOFF_BIT];
        end else begin
            mac_alt_r <= mac_alt_nxt;
            mac_rsv_hi_r <= mac_rsv_hi_nxt;
            mac_len_chk_r <= mac_len_chk_nxt;
            mac_rsv_lo_r <= mac_rsv_lo_nxt;
            mac_fc_mode_r <= mac_fc_mode_nxt;
            mac_aggr_r <= mac_aggr_nxt;
        end
    end

    // Collision policy register.
    always @* begin
        coll_keep_nxt = coll_keep_r;
        if (wr_coll) begin
            coll_keep_nxt = wdata[`COLL_KEEP_BIT];
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            coll_keep_r <= `COLL_POLICY_RESET;
        end else begin
            coll_keep_r <= coll_keep_nxt;
        end
    end

    // Read data for the addressed register; unmapped reads return zero.
    always @* begin
        rdata_nxt = 32'h0000_0000;
        if (sel_uvf) begin
            rdata_nxt[`UVF_EN_BIT] = uvf_en_r;
            rdata_nxt[`UVF_MASK_MSB:`UVF_MASK_LSB] = uvf_mask_r;
        end else if (sel_mac) begin
            rdata_nxt[7:0] = mac_ctrl_word;
        end else if (sel_coll) begin
            rdata_nxt[`COLL_KEEP_BIT] = coll_keep_r;
        end
    end

    // Read data stands only in the cycle after the strobe.
    always @(posedge clk) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (rd_en) begin
            rdata <= rdata_nxt;
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    // Highest-precedence unknown category picks the forwarding set.
    always @* begin
        class_nxt = `CLASS_NONE;
        hit_nxt = 1'b0;
        cat_mask = 7'h00;
        if (rx_unknown_vid) begin
            class_nxt = `CLASS_UVID;
            hit_nxt = uvf_en_r;
            cat_mask = uvf_mask_r;
        end else if (rx_unknown_ucast) begin
            class_nxt = `CLASS_UUCAST;
            hit_nxt = ucast_fwd_en;
            cat_mask = ucast_fwd_mask;
        end else if (rx_unknown_mcast) begin
            class_nxt = `CLASS_UMCAST;
            hit_nxt = mcast_fwd_en;
            cat_mask = mcast_fwd_mask;
        end
    end

    // Each port bit forwards only when the category's override applies.
    genvar port_idx;
    generate
        for (port_idx = 0; port_idx < 7; port_idx = port_idx + 1) begin : g_fwd_port
            assign mask_nxt[port_idx] = hit_nxt & cat_mask[port_idx];
        end
    endgenerate

    frame_filter u_filter (
        .len_check_en(len_check_en),
        .fc_drop_mode(fc_drop_mode),
        .ethertype(rx_ethertype),
        .dest_addr(rx_dest_addr),
        .actual_len(rx_actual_len),
        .drop(filt_drop),
        .len_drop(filt_len_drop),
        .fc_drop(filt_fc_drop)
    );

    // Decision fields are held until the next frame is offered.
    always @* begin
        dec_drop_nxt = dec_drop;
        dec_len_drop_nxt = dec_len_drop;
        dec_fc_drop_nxt = dec_fc_drop;
        dec_fwd_hit_nxt = dec_fwd_hit;
        dec_fwd_mask_nxt = dec_fwd_mask;
        dec_class_nxt = dec_class;
        if (rx_valid) begin
            dec_drop_nxt = filt_drop;
            dec_len_drop_nxt = filt_len_drop;
            dec_fc_drop_nxt = filt_fc_drop;
            dec_fwd_hit_nxt = hit_nxt;
            dec_fwd_mask_nxt = mask_nxt;
            dec_class_nxt = class_nxt;
        end
    end

    // Decision for each received frame, one cycle after it is offered.
    always @(posedge clk) begin
        if (rst) begin
            dec_valid <= 1'b0;
            dec_drop <= 1'b0;
            dec_len_drop <= 1'b0;
            dec_fc_drop <= 1'b0;
            dec_fwd_hit <= 1'b0;
            dec_fwd_mask <= 7'h00;
            dec_class <= `CLASS_NONE;
        end else begin
            dec_valid <= rx_valid;
            dec_drop <= dec_drop_nxt;
            dec_len_drop <= dec_len_drop_nxt;
            dec_fc_drop <= dec_fc_drop_nxt;
            dec_fwd_hit <= dec_fwd_hit_nxt;
            dec_fwd_mask <= dec_fwd_mask_nxt;
            dec_class <= dec_class_nxt;
        end
    end

    // Alternate back-off should accompany collision keep in software.
    backoff_sel u_backoff (
        .clk(clk),
        .rst(rst),
        .alt_en(alt_en),
        .aggr_en(aggr_en),
        .keep_exc_coll(coll_keep_r),
        .half_duplex(half_duplex),
        .exc_coll(exc_coll),
        .alt_backoff(alt_backoff),
        .aggr_backoff(aggr_backoff),
        .exc_coll_drop(exc_coll_drop)
    );

endmodule // unknown_vid_and_mac_ctrl

`default_nettype wire

// ### tb/ctrl_assertions.sv
`default_nettype none
module ctrl_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic rx_valid,
    input wire logic rx_unknown_vid,
    input wire logic [15:0] rx_ethertype,
    input wire logic dec_valid,
    input wire logic dec_drop,
    input wire logic dec_len_drop,
    input wire logic dec_fc_drop,
    input wire logic dec_fwd_hit,
    input wire logic [6:0] dec_fwd_mask,
    input wire logic [1:0] dec_class,
    input wire logic [6:0] half_duplex,
    input wire logic [6:0] alt_backoff,
    input wire logic [6:0] aggr_backoff,
    input wire logic len_check_en,
    input wire logic fc_drop_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_vid;
        rx_valid && rx_unknown_vid |=> dec_valid && dec_class == 2'h1;
    endproperty
    a_vid: assert property (p_vid) else $error("vid class");
    property p_nohit;
        dec_valid && !dec_fwd_hit |-> dec_fwd_mask == 7'h0;
    endproperty
    a_nohit: assert property (p_nohit) else $error("mask no hit");
    property p_fc1;
        rx_valid && fc_drop_mode && rx_ethertype == 16'h8808 |=> dec_fc_drop;
    endproperty
    a_fc1: assert property (p_fc1) else $error("fc one");
    property p_fc0;
        rx_valid && !fc_drop_mode && rx_ethertype != 16'h8808 |=> !dec_fc_drop;
    endproperty
    a_fc0: assert property (p_fc0) else $error("fc zero");
    property p_len;
        rx_valid && !len_check_en |=> !dec_len_drop;
    endproperty
    a_len: assert property (p_len) else $error("len off");
    property p_drop;
        dec_valid |-> dec_drop == (dec_len_drop | dec_fc_drop);
    endproperty
    a_drop: assert property (p_drop) else $error("drop sum");
    property p_alt;
        (alt_backoff & ~$past(half_duplex)) == 7'h0;
    endproperty
    a_alt: assert property (p_alt) else $error("alt");
    property p_agg;
        (aggr_backoff & ~$past(half_duplex)) == 7'h0;
    endproperty
    a_agg: assert property (p_agg) else $error("aggr");
endmodule // ctrl_chk
bind unknown_vid_and_mac_ctrl ctrl_chk ctrl_chk_inst (.*);
`default_nettype wire

// ### tb/tb_top.sv
`default_nettype none
`include "switch_ctrl_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, wr_en, rd_en, rx_valid, rx_unknown_vid, rx_unknown_ucast;
    logic rx_unknown_mcast, ucast_fwd_en, mcast_fwd_en, dec_valid, dec_drop;
    logic dec_len_drop, dec_fc_drop, dec_fwd_hit, len_check_en, fc_drop_mode;
    logic [11:0] addr;
    logic [31:0] wdata, rdata;
    logic [15:0] rx_ethertype, rx_actual_len;
    logic [47:0] rx_dest_addr;
    logic [6:0] ucast_fwd_mask, mcast_fwd_mask, dec_fwd_mask, half_duplex, exc_coll;
    logic [6:0] alt_backoff, aggr_backoff, exc_coll_drop;
    logic [1:0] dec_class;
    int miscompares, cmp_count;
    unknown_vid_and_mac_ctrl unknown_vid_and_mac_ctrl_inst (.*);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task chk(input string n, input logic [47:0] e, input logic [47:0] g);
        cmp_count++;
        if (e !== g) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk("rdata", e, rdata);
    endtask
    task fr(input logic [2:0] c, input logic [15:0] t, input logic [47:0] d, input logic [15:0] l);
        @(posedge clk);
        {rx_unknown_vid, rx_unknown_ucast, rx_unknown_mcast} <= c;
        rx_ethertype <= t;
        rx_dest_addr <= d;
        rx_actual_len <= l;
        rx_valid <= 1'b1;
        @(posedge clk);
        rx_valid <= 1'b0;
        #1 chk("dec_valid", 1'h1, dec_valid);
    endtask
    task t_regs();
        rd(`UVF_CTRL_OFFSET, 32'h0);
        rd(`MAC_CTRL_ZERO_OFFSET, 32'h4);
        wr(`UVF_CTRL_OFFSET, 32'hffff_ffff);
        wr(12'h32c, 32'hffff_ffff);
        rd(`UVF_CTRL_OFFSET, 32'h8000_007f);
        rd(12'h32c, 32'h0);
        @(posedge clk);
        #1 chk("rdata", 32'h0, rdata);
        $display("t_regs end");
    endtask
    task t_fwd();
        for (int i = 0; i < 7; i++) begin
            wr(`UVF_CTRL_OFFSET, 32'h8000_0000 | (32'h1 << i));
            fr(3'h7, 16'h0800, 48'h0, 16'h0040);
            chk("class", `CLASS_UVID, dec_class);
            chk("mask", 48'h1 << i, dec_fwd_mask);
            chk("hit", 1'h1, dec_fwd_hit);
        end
        @(posedge clk);
        ucast_fwd_en <= 1'b1;
        ucast_fwd_mask <= 7'h2a;
        mcast_fwd_en <= 1'b1;
        mcast_fwd_mask <= 7'h15;
        wr(`UVF_CTRL_OFFSET, 32'h7f);
        fr(3'h7, 16'h0800, 48'h0, 16'h0040);
        chk("hit", 1'h0, dec_fwd_hit);
        fr(3'h3, 16'h0800, 48'h0, 16'h0040);
        chk("mask", 7'h2a, dec_fwd_mask);
        chk("class", `CLASS_UUCAST, dec_class);
        fr(3'h1, 16'h0800, 48'h0, 16'h0040);
        chk("class", `CLASS_UMCAST, dec_class);
        chk("mask", 7'h15, dec_fwd_mask);
        $display("t_fwd end");
    endtask
    task t_fc();
        for (int k = 0; k < 8; k++) begin
            wr(`MAC_CTRL_ZERO_OFFSET, k[2] ? 32'h6 : 32'h4);
            fr(3'h0, k[1] ? `FC_ETHERTYPE : 16'h0800, k[0] ? `FC_DEST_ADDR : 48'h0, 16'h40);
            chk("fc_drop", k[2] ? |k[1:0] : &k[1:0], dec_fc_drop);
            chk("drop", k[2] ? |k[1:0] : &k[1:0], dec_drop);
            chk("fc_mode", k[2], fc_drop_mode);
        end
        $display("t_fc end");
    endtask
    task t_len();
        wr(`MAC_CTRL_ZERO_OFFSET, 32'hc);
        fr(3'h0, 16'h05db, 48'h0, 16'h05dc);
        chk("len_drop", 1'h1, dec_len_drop);
        chk("len_en", 1'h1, len_check_en);
        fr(3'h0, 16'h05dc, 48'h0, 16'h0040);
        chk("len_drop", 1'h0, dec_len_drop);
        fr(3'h0, 16'h0040, 48'h0, 16'h0040);
        chk("len_drop", 1'h0, dec_len_drop);
        wr(`MAC_CTRL_ZERO_OFFSET, 32'h4);
        fr(3'h0, 16'h05db, 48'h0, 16'h05dc);
        chk("drop", 1'h0, dec_drop);
        $display("t_len end");
    endtask
    task t_bo();
        @(posedge clk);
        half_duplex <= 7'h55;
        exc_coll <= 7'h7f;
        wr(`MAC_CTRL_ZERO_OFFSET, 32'h85);
        repeat (2) @(posedge clk);
        #1 chk("alt", 7'h55, alt_backoff);
        chk("aggr", 7'h55, aggr_backoff);
        chk("exc", 7'h7f, exc_coll_drop);
        wr(`COLL_POLICY_OFFSET, 32'h1);
        wr(`MAC_CTRL_ZERO_OFFSET, 32'h84);
        repeat (2) @(posedge clk);
        #1 chk("exc", 7'h0, exc_coll_drop);
        chk("aggr", 7'h0, aggr_backoff);
        $display("t_bo end");
    endtask
    task t_rst();
        wr(`UVF_CTRL_OFFSET, 32'h8000_0015);
        wr(`MAC_CTRL_ZERO_OFFSET, 32'h8e);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk("len_en", 1'h0, len_check_en);
        chk("fc_mode", 1'h0, fc_drop_mode);
        chk("alt", 7'h0, alt_backoff);
        chk("dec_valid", 1'h0, dec_valid);
        rd(`UVF_CTRL_OFFSET, 32'h0);
        rd(`MAC_CTRL_ZERO_OFFSET, 32'h4);
        rd(`COLL_POLICY_OFFSET, 32'h0);
        $display("t_rst end");
    endtask
    task give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        {wr_en, rd_en, rx_valid, rx_unknown_vid, rx_unknown_ucast, rx_unknown_mcast} = '0;
        {addr, wdata, rx_ethertype, rx_dest_addr, rx_actual_len} = '0;
        {ucast_fwd_en, mcast_fwd_en, ucast_fwd_mask, mcast_fwd_mask, half_duplex, exc_coll} = '0;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_fwd();
        t_fc();
        t_len();
        t_bo();
        t_rst();
        give_verdict();
    end
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
